/* scmc_pkg.sv */
package scmc_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CLKCTL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_CPUCTL   = 4'h8;
  localparam int         BIT_CLK_SEL   = 5;
  localparam int         BIT_FAST_STB  = 3;
  localparam int         BIT_FAST_EN   = 2;
  localparam int         BIT_FAST_HALT = 1;
  localparam int         BIT_SLOW_HALT = 0;
  localparam logic [7:0] CLKCTL_WMASK  = 8'h27;
  localparam logic [7:0] CLKCTL_RESET  = 8'h20;
  // Status register bits
  localparam int         BIT_PWRDN     = 0;
  localparam int         BIT_WDTO      = 1;
  localparam int         BIT_CPU_RUN   = 2;
  localparam int         BIT_SYS_FAST  = 3;
  // Command register bits (write one to act)
  localparam int         BIT_HALT      = 0;
  localparam int         BIT_WAKE      = 1;
  localparam int         BIT_WDT_CLR   = 2;
  localparam int         BIT_FREQ_CHG  = 3;
  localparam int         BIT_WDT_TOUT  = 4;
  // ---------------------------------------------------------------
  // Oscillators and timing
  // ---------------------------------------------------------------
  localparam longint FAST_OSC_HZ   = 64'd8000000;
  localparam longint SLOW_OSC_HZ   = 64'd32768;
  localparam longint SYS_CLK_HZ    = 64'd10000000;
  localparam int     SLOW_DIV      = 8;
  localparam int     FAST_STABLE_N = 16;
  localparam int     OSC_ACC_W     = 24;
  localparam logic [OSC_ACC_W-1:0] FAST_INC = OSC_ACC_W'((FAST_OSC_HZ << OSC_ACC_W) / SYS_CLK_HZ);
  localparam logic [OSC_ACC_W-1:0] SLOW_INC = OSC_ACC_W'((SLOW_OSC_HZ << OSC_ACC_W) / SYS_CLK_HZ);
  localparam int     WDT_W         = 16;

  typedef enum logic [2:0] {
    MODE_FAST, MODE_SLOW, MODE_SLEEP, MODE_STBY_LOW, MODE_STBY_BOTH, MODE_STBY_HIGH
  } scmc_mode_t;
endpackage

/* scmc_osc.sv */
`timescale 1ns/1ps
// Phase accumulator model of one RC oscillator: one tick per its edge.
module scmc_osc import scmc_pkg::*; #(
  parameter logic [OSC_ACC_W-1:0] INC = FAST_INC
) (
  // Clock and reset
  input  wire logic sysClk,
  input  wire logic rstN,
  // Control
  input  wire logic enable,
  // Edge tick
  output logic      tick
);
  typedef struct packed {
    logic [OSC_ACC_W-1:0] acc;
    logic                 tick;
  } scmc_osc_st_t;
  scmc_osc_st_t st_q, st_d;

  always_comb begin
    logic [OSC_ACC_W:0] sum;
    sum = {1'b0, st_q.acc} + {1'b0, INC};
    st_d = st_q;
    st_d.tick = 1'b0;
    if (enable) begin
      st_d.acc  = sum[OSC_ACC_W-1:0];
      st_d.tick = sum[OSC_ACC_W];
    end else begin
      st_d.acc = '0;
    end
  end

  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) st_q <= '0;
    else       st_q <= st_d;
  end

  assign tick = st_q.tick;
endmodule // scmc_osc

/* scmc_clock_ctrl.sv */
`timescale 1ns/1ps
module scmc_clock_ctrl import scmc_pkg::*; (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU core
  input  wire logic        haltReq,
  input  wire logic        wakeReq,
  input  wire logic        wdtEnable,
  output logic             cpuRun,
  output logic [2:0]       opMode,
  // Clock enables to consumers
  output logic             fastOscEn,
  output logic             slowOscEn,
  output logic             highClkTick,
  output logic             lowClkTick,
  output logic             sysClkTick,
  output logic             wdtClkTick,
  // Watchdog flags
  output logic             powerDownFlag,
  output logic             wdtTimeoutFlag,
  output logic [15:0]      wdtCount
);
  // ---------------------------------------------------------------
  // Reset synchroniser
  // ---------------------------------------------------------------
  logic [1:0] rstSync_q;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) rstSync_q <= 2'h0;
    else          rstSync_q <= {rstSync_q[0], 1'b1};
  end
  wire logic rstN = rstSync_q[1];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             awDone;
    logic             wDone;
    logic [3:0]       awAddr;
    logic [31:0]      wData;
    logic [3:0]       wStrb;
    logic             bValid;
    logic [1:0]       bResp;
    logic             rValid;
    logic [31:0]      rData;
    logic [1:0]       rResp;
    logic             clkSel;
    logic             fastEn;
    logic             fastKeep;
    logic             slowKeep;
    logic             fastStable;
    logic [4:0]       stableCnt;
    logic [4:0]       stallCnt;
    logic             muxFast;
    scmc_mode_t       mode;
    logic [2:0]       divCnt;
    logic             pdFlag;
    logic             toFlag;
    logic [WDT_W-1:0] wdt;
    logic             cpuRun;
    logic             fastOn;
    logic             slowOn;
    logic             highTick;
    logic             lowTick;
    logic             sysTick;
    logic             wdtTick;
  } scmc_st_t;
  scmc_st_t st_q, st_d;

  logic fastTick;
  logic slowTick;

  // Oscillators run only while enabled
  scmc_osc #(.INC(FAST_INC)) u_fast (
    .sysClk (sys_clk),
    .rstN   (rstN),
    .enable (st_q.fastOn),
    .tick   (fastTick)
  );
  scmc_osc #(.INC(SLOW_INC)) u_slow (
    .sysClk (sys_clk),
    .rstN   (rstN),
    .enable (st_q.slowOn),
    .tick   (slowTick)
  );

  function automatic logic [7:0] mergeByte(input logic [7:0] old, input logic [7:0] nw,
                                           input logic [7:0] msk);
    mergeByte = (old & ~msk) | (nw & msk);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] ctl;
    logic [7:0] wr;
    logic       wrGo;
    logic       haltEv;
    logic       wakeEv;
    logic       wdtClr;
    logic       freqChg;
    logic       wdtTout;
    logic       halted;
    logic       wantFast;
    logic       highOn;
    logic       lowOn;
    logic       sysOn;
    logic       divOn;
    st_d     = st_q;
    ctl      = 8'h00;
    wr       = 8'h00;
    haltEv   = haltReq;
    wakeEv   = wakeReq;
    wdtClr   = 1'b0;
    freqChg  = 1'b0;
    wdtTout  = 1'b0;
    wrGo     = 1'b0;
    halted   = 1'b0;
    wantFast = 1'b0;
    highOn   = 1'b0;
    lowOn    = 1'b0;
    sysOn    = 1'b0;
    divOn    = 1'b0;

    ctl[BIT_CLK_SEL]   = st_q.clkSel;
    ctl[BIT_FAST_STB]  = st_q.fastStable;
    ctl[BIT_FAST_EN]   = st_q.fastEn;
    ctl[BIT_FAST_HALT] = st_q.fastKeep;
    ctl[BIT_SLOW_HALT] = st_q.slowKeep;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && !st_q.awDone && !st_q.bValid) begin
      st_d.awDone = 1'b1;
      st_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_q.wDone && !st_q.bValid) begin
      st_d.wDone = 1'b1;
      st_d.wData = s_axi_wdata;
      st_d.wStrb = s_axi_wstrb;
    end
    if (st_q.awDone && st_q.wDone) begin
      wrGo        = st_q.wStrb[0];
      st_d.awDone = 1'b0;
      st_d.wDone  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = 2'b00;
      unique case (st_q.awAddr)
        ADDR_CLKCTL: begin
          wr = mergeByte(ctl, st_q.wData[7:0], CLKCTL_WMASK);
          if (wrGo) begin
            st_d.clkSel   = wr[BIT_CLK_SEL];
            st_d.fastEn   = wr[BIT_FAST_EN];
            st_d.fastKeep = wr[BIT_FAST_HALT];
            st_d.slowKeep = wr[BIT_SLOW_HALT];
          end
        end
        ADDR_CPUCTL: begin
          if (wrGo) begin
            haltEv  = haltEv | st_q.wData[BIT_HALT];
            wakeEv  = wakeEv | st_q.wData[BIT_WAKE];
            wdtClr  = st_q.wData[BIT_WDT_CLR];
            freqChg = st_q.wData[BIT_FREQ_CHG];
            wdtTout = st_q.wData[BIT_WDT_TOUT];
          end
        end
        ADDR_STATUS: ;
        default: st_d.bResp = 2'b10;
      endcase
    end
    if (st_q.bValid && s_axi_bready) st_d.bValid = 1'b0;

    // Read channel
    if (s_axi_arvalid && !st_q.rValid) begin
      st_d.rValid = 1'b1;
      st_d.rResp  = 2'b00;
      st_d.rData  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_CLKCTL: st_d.rData[7:0] = ctl;
        ADDR_STATUS: begin
          st_d.rData[BIT_PWRDN]    = st_q.pdFlag;
          st_d.rData[BIT_WDTO]     = st_q.toFlag;
          st_d.rData[BIT_CPU_RUN]  = st_q.cpuRun;
          st_d.rData[BIT_SYS_FAST] = st_q.muxFast;
        end
        ADDR_CPUCTL: ;
        default: st_d.rResp = 2'b10;
      endcase
    end
    if (st_q.rValid && s_axi_rready) st_d.rValid = 1'b0;

    // ---------------------------------------------------------------
    // Operating mode
    // ---------------------------------------------------------------
    halted = (st_q.mode != MODE_FAST) && (st_q.mode != MODE_SLOW);
    if (!halted && haltEv) begin
      unique case ({st_q.fastKeep, st_q.slowKeep})
        2'b00: st_d.mode = MODE_SLEEP;
        2'b01: st_d.mode = MODE_STBY_LOW;
        2'b11: st_d.mode = MODE_STBY_BOTH;
        2'b10: st_d.mode = MODE_STBY_HIGH;
      endcase
      st_d.pdFlag = 1'b1;
      st_d.toFlag = 1'b0;
      st_d.wdt    = '0;
    end else if (halted && wakeEv) begin
      st_d.mode = st_q.clkSel ? MODE_SLOW : MODE_FAST;
    end else if (!halted) begin
      st_d.mode = st_q.clkSel ? MODE_SLOW : MODE_FAST;
    end
    if (wdtClr) begin
      st_d.pdFlag = haltEv && !halted;
      st_d.toFlag = 1'b0;
      st_d.wdt    = '0;
    end
    // A timeout in the same cycle as a clear still lands
    if (wdtTout) st_d.toFlag = 1'b1;

    // Fast oscillator: held by enable, by a halt keep, or while still the source
    unique case (st_q.mode)
      MODE_FAST: st_d.fastOn = 1'b1;
      MODE_SLOW: st_d.fastOn = st_q.fastEn || st_q.muxFast;
      MODE_SLEEP, MODE_STBY_LOW: st_d.fastOn = 1'b0;
      MODE_STBY_BOTH, MODE_STBY_HIGH: st_d.fastOn = 1'b1;
    endcase
    // Slow oscillator stays up in sleep only while wdtEnable keeps the watchdog divider on
    unique case (st_q.mode)
      MODE_SLEEP:     st_d.slowOn = wdtEnable;
      MODE_STBY_HIGH: st_d.slowOn = 1'b1;
      default:        st_d.slowOn = 1'b1;
    endcase

    // Stability counter restarts whenever the oscillator is off
    if (!st_q.fastOn) begin
      st_d.stableCnt  = 5'h00;
      st_d.fastStable = 1'b0;
    end else if (fastTick && !st_q.fastStable) begin
      st_d.stableCnt = st_q.stableCnt + 5'h01;
      if (st_q.stableCnt == 5'(FAST_STABLE_N - 1)) st_d.fastStable = 1'b1;
    end

    // Mux changes over only on a tick of the target, and to the fast source only once it is stable
    wantFast = !st_q.clkSel || st_q.mode == MODE_STBY_HIGH;
    if (wantFast && !st_q.muxFast && st_q.fastStable && fastTick) st_d.muxFast = 1'b1;
    if (!wantFast && st_q.muxFast && slowTick) st_d.muxFast = 1'b0;

    // Frequency change stall on the fast source
    if (freqChg && st_q.muxFast) begin
      st_d.stallCnt = 5'(FAST_STABLE_N);
    end else if (st_q.stallCnt != 5'h00 && fastTick) begin
      st_d.stallCnt = st_q.stallCnt - 5'h01;
    end

    // Consumer clocks
    highOn = st_q.fastOn && st_q.fastStable;
    unique case (st_q.mode)
      MODE_SLEEP, MODE_STBY_HIGH: lowOn = 1'b0;
      default:                    lowOn = 1'b1;
    endcase
    unique case (st_q.mode)
      MODE_FAST, MODE_SLOW, MODE_STBY_BOTH: sysOn = 1'b1;
      MODE_STBY_LOW:  sysOn = st_q.clkSel;
      MODE_STBY_HIGH: sysOn = !st_q.clkSel;
      MODE_SLEEP:     sysOn = 1'b0;
    endcase
    divOn = st_q.mode != MODE_SLEEP || wdtEnable;

    // Divide-by-eight of the slow oscillator
    st_d.wdtTick = 1'b0;
    if (slowTick && divOn) begin
      st_d.divCnt  = st_q.divCnt + 3'h1;
      st_d.wdtTick = st_q.divCnt == 3'(SLOW_DIV - 1);
    end
    if (st_q.wdtTick && wdtEnable && !(haltEv && !halted) && !wdtClr) begin
      st_d.wdt = st_q.wdt + WDT_W'(1);
    end

    st_d.highTick = highOn && fastTick;
    st_d.lowTick  = lowOn && slowTick;
    st_d.sysTick  = sysOn && (st_q.muxFast ? fastTick : slowTick);
    st_d.cpuRun   = !halted && st_q.stallCnt == 5'h00 && !(haltEv && !halted);
  end

  // Power-on state: slow mode with the slow oscillator already running
  always_ff @(posedge sys_clk or negedge rstN) begin
    if (!rstN) begin
      st_q        <= '0;
      st_q.clkSel <= CLKCTL_RESET[BIT_CLK_SEL];
      st_q.mode   <= MODE_SLOW;
      st_q.slowOn <= 1'b1;
      st_q.rData  <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready  = !st_q.awDone && !st_q.bValid;
  assign s_axi_wready   = !st_q.wDone && !st_q.bValid;
  assign s_axi_bvalid   = st_q.bValid;
  assign s_axi_bresp    = st_q.bResp;
  assign s_axi_arready  = !st_q.rValid;
  assign s_axi_rvalid   = st_q.rValid;
  assign s_axi_rdata    = st_q.rData;
  assign s_axi_rresp    = st_q.rResp;
  assign cpuRun         = st_q.cpuRun;
  assign opMode         = st_q.mode;
  assign fastOscEn      = st_q.fastOn;
  assign slowOscEn      = st_q.slowOn;
  assign highClkTick    = st_q.highTick;
  assign lowClkTick     = st_q.lowTick;
  assign sysClkTick     = st_q.sysTick;
  assign wdtClkTick     = st_q.wdtTick;
  assign powerDownFlag  = st_q.pdFlag;
  assign wdtTimeoutFlag = st_q.toFlag;
  assign wdtCount       = st_q.wdt;
endmodule // scmc_clock_ctrl

/* scmc_clock_ctrl_assertions.sv */
`timescale 1ns/1ps
module scmc_checker import scmc_pkg::*; (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        reset_n,
  // CPU side
  input wire logic        wdtEnable,
  input wire logic        cpuRun,
  input wire logic [2:0]  opMode,
  // Clocks and flags
  input wire logic        fastOscEn,
  input wire logic        slowOscEn,
  input wire logic        highClkTick,
  input wire logic        lowClkTick,
  input wire logic        sysClkTick,
  input wire logic        wdtClkTick,
  input wire logic        powerDownFlag,
  input wire logic        wdtTimeoutFlag,
  input wire logic [15:0] wdtCount
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ------
  // Mode checks on high, low and system ticks wait two cycles: ticks are registered
  // ------
  sleep_clocks_off_a:
    assert property (opMode == MODE_SLEEP && $past(opMode, 2) == MODE_SLEEP
      |-> !highClkTick && !lowClkTick && !sysClkTick) else $error("clock ticks in sleep");
  sleep_wdt_gate_a:
    assert property (opMode == MODE_SLEEP && $past(opMode) == MODE_SLEEP && !wdtEnable
      && !$past(wdtEnable) |-> !wdtClkTick) else $error("watchdog tick while disabled");
  low_standby_a:
    assert property (opMode == MODE_STBY_LOW && $past(opMode, 2) == MODE_STBY_LOW
      |-> !highClkTick && slowOscEn) else $error("low standby clocks wrong");
  both_standby_a:
    assert property (opMode == MODE_STBY_BOTH && $past(opMode) == MODE_STBY_BOTH
      |-> fastOscEn && slowOscEn) else $error("both standby oscillator off");
  high_standby_a:
    assert property (opMode == MODE_STBY_HIGH && $past(opMode, 2) == MODE_STBY_HIGH
      |-> !lowClkTick && fastOscEn) else $error("high standby clocks wrong");
  fast_mode_osc_a:
    assert property (opMode == MODE_FAST |-> fastOscEn && slowOscEn)
      else $error("oscillator off in fast mode");
  halt_entry_flags_a:
    assert property (opMode >= 3'h2 && $past(opMode) <= 3'h1
      |-> powerDownFlag && !wdtTimeoutFlag && wdtCount == 16'h0000)
      else $error("halt flags wrong");
  halt_cpu_off_a:
    assert property (opMode >= 3'h2 && $past(opMode) >= 3'h2 |-> !cpuRun)
      else $error("cpu runs while halted");
  sys_src_tick_a:
    assert property (sysClkTick |-> highClkTick || lowClkTick)
      else $error("system tick without source tick");
  fast_off_quiet_a:
    assert property (!fastOscEn && !$past(fastOscEn) |-> !highClkTick)
      else $error("high tick with fast oscillator off");
endmodule // scmc_checker

bind scmc_clock_ctrl scmc_checker i_chk (.sys_clk, .reset_n, .wdtEnable, .cpuRun, .opMode,
  .fastOscEn, .slowOscEn, .highClkTick, .lowClkTick, .sysClkTick, .wdtClkTick,
  .powerDownFlag, .wdtTimeoutFlag, .wdtCount);

/* scmc_cpu_model.sv */
`timescale 1ns/1ps
// CPU core and clock consumers: issues halt and wake, counts every tick
module scmc_cpu_model (
  // Clock
  input  wire logic sys_clk,
  // From the block
  input  wire logic cpuRun,
  input  wire logic highClkTick,
  input  wire logic lowClkTick,
  input  wire logic sysClkTick,
  input  wire logic wdtClkTick,
  // To the block
  output logic      haltReq,
  output logic      wakeReq,
  output logic      wdtEnable
);
  int nHigh = 0, nLow = 0, nSys = 0, nWdt = 0, nStall = 0;
  initial begin
    haltReq = 1'b0;
    wakeReq = 1'b0;
    wdtEnable = 1'b0;
  end
  // Free-running counters; readers take differences so nothing is cleared
  always @(posedge sys_clk) begin
    nHigh <= nHigh + int'(highClkTick);
    nLow <= nLow + int'(lowClkTick);
    nSys <= nSys + int'(sysClkTick);
    nWdt <= nWdt + int'(wdtClkTick);
    nStall <= nStall + int'(highClkTick && !cpuRun);
  end
  task automatic halt();
    @(posedge sys_clk);
    haltReq <= 1'b1;
    @(posedge sys_clk);
    haltReq <= 1'b0;
  endtask
  task automatic wake();
    @(posedge sys_clk);
    wakeReq <= 1'b1;
    @(posedge sys_clk);
    wakeReq <= 1'b0;
  endtask
  task automatic setWdt(input logic v);
    @(posedge sys_clk);
    wdtEnable <= v;
  endtask
endmodule // scmc_cpu_model

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end
module testbench import scmc_pkg::*;;
  logic        reset_n = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sys_clk;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  opMode;
  logic [15:0] wdtCount;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        haltReq, wakeReq, wdtEnable, cpuRun, fastOscEn, slowOscEn, powerDownFlag;
  logic        highClkTick, lowClkTick, sysClkTick, wdtClkTick, wdtTimeoutFlag;
  int          n_mismatch = 0, tests_run = 0, dH, dL, dS, dW;
  // Halt table: {watchdog enable, fast keep, slow keep} and the mode it must give
  logic [2:0]  haltCfg [5] = '{3'b000, 3'b100, 3'b001, 3'b011, 3'b010};
  logic [2:0]  expMode [5] = '{MODE_SLEEP, MODE_SLEEP, MODE_STBY_LOW, MODE_STBY_BOTH,
                               MODE_STBY_HIGH};

  scmc_clock_ctrl i_dut (.sys_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .haltReq, .wakeReq, .wdtEnable, .cpuRun, .opMode,
    .fastOscEn, .slowOscEn, .highClkTick, .lowClkTick, .sysClkTick, .wdtClkTick,
    .powerDownFlag, .wdtTimeoutFlag, .wdtCount);
  scmc_cpu_model i_cpu (.sys_clk, .cpuRun, .highClkTick, .lowClkTick, .sysClkTick,
    .wdtClkTick, .haltReq, .wakeReq, .wdtEnable);

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ------
  // Bus and helper tasks
  // ------
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic fail_wait();
    n_mismatch++;
    $display("Error at %0t: wait ran out, got %0h expected %0h", $time, 1'b0, 1'b1);
    complete_run();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic [3:0] s,
                    output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1) fail_wait();
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1) fail_wait();
  endtask
  task automatic pollst(input int b, input logic v);
    logic [7:0] d;
    logic [1:0] r;
    int n = 0;
    do begin
      rd(ADDR_STATUS, d, r);
      n++;
    end while (d[b] !== v && n < 200);
    if (d[b] !== v) fail_wait();
  endtask
  task automatic measure(input int n);
    int h = i_cpu.nHigh, l = i_cpu.nLow, s = i_cpu.nSys, w = i_cpu.nWdt;
    repeat (n) @(posedge sys_clk);
    dH = i_cpu.nHigh - h;
    dL = i_cpu.nLow - l;
    dS = i_cpu.nSys - s;
    dW = i_cpu.nWdt - w;
  endtask
  // ------
  // Main sequence
  // ------
  initial begin
    logic [7:0] d;
    logic [1:0] r;
    int t;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(opMode, MODE_SLOW)
    rd(ADDR_CLKCTL, d, r);
    `CHK(d, 8'h20)
    wr(ADDR_CLKCTL, 8'hF0, 4'hF, r);
    rd(ADDR_CLKCTL, d, r);
    `CHK(d, 8'h20)
    wr(ADDR_CLKCTL, 8'h27, 4'hE, r);
    rd(ADDR_CLKCTL, d, r);
    `CHK(d, 8'h20)
    wr(4'hC, 8'h01, 4'hF, r);
    `CHK(r, 2'b10)
    rd(4'hC, d, r);
    `CHK(r, 2'b10)
    $display("test registers done");
    wr(ADDR_CLKCTL, 8'h24, 4'hF, r);
    rd(ADDR_CLKCTL, d, r);
    `CHK(d, 8'h24)
    measure(40);
    rd(ADDR_CLKCTL, d, r);
    `CHK(d, 8'h2C)
    measure(20000);
    `CHK(dH inside {[15998:16002]}, 1'b1)
    `CHK(dL inside {[65:66]}, 1'b1)
    `CHK(dS, dL)
    `CHK(dW inside {[dL / 8 - 1:dL / 8 + 1]}, 1'b1)
    `CHK(cpuRun, 1'b1)
    $display("test slow mode done");
    wr(ADDR_CLKCTL, 8'h04, 4'hF, r);
    pollst(BIT_SYS_FAST, 1'b1);
    `CHK(opMode, MODE_FAST)
    measure(1000);
    `CHK(dS, dH)
    `CHK(dL > 0, 1'b1)
    t = i_cpu.nStall;
    wr(ADDR_CPUCTL, 8'h08, 4'hF, r);
    repeat (60) @(posedge sys_clk);
    `CHK((i_cpu.nStall - t) inside {[15:17]}, 1'b1)
    `CHK(cpuRun, 1'b1)
    wr(ADDR_CLKCTL, 8'h20, 4'hF, r);
    pollst(BIT_SYS_FAST, 1'b0);
    measure(10);
    `CHK(fastOscEn, 1'b0)
    `CHK(opMode, MODE_SLOW)
    rd(ADDR_CLKCTL, d, r);
    `CHK(d, 8'h20)
    $display("test fast mode done");
    foreach (haltCfg[i]) begin
      i_cpu.setWdt(haltCfg[i][2]);
      wr(ADDR_CPUCTL, 8'h10, 4'hF, r);
      wr(ADDR_CLKCTL, {6'b001000, haltCfg[i][1:0]}, 4'hF, r);
      `CHK(wdtTimeoutFlag, 1'b1)
      i_cpu.halt();
      repeat (3) @(posedge sys_clk);
      `CHK(opMode, expMode[i])
      `CHK({powerDownFlag, wdtTimeoutFlag, cpuRun}, 3'b100)
      `CHK(wdtCount, 16'h0000)
      measure(5000);
      `CHK(dH > 0, haltCfg[i][1])
      `CHK(dL > 0, haltCfg[i][0])
      `CHK(dS > 0, haltCfg[i][0])
      `CHK(dW > 0, haltCfg[i] != 3'b000)
      rd(ADDR_STATUS, d, r);
      `CHK(d[2:0], 3'b001)
      i_cpu.wake();
      t = 0;
      while (cpuRun !== 1'b1 && t < 2000) begin
        @(posedge sys_clk);
        t++;
      end
      if (cpuRun !== 1'b1) fail_wait();
    end
    $display("test halt modes done");
    wr(ADDR_CPUCTL, 8'h01, 4'hF, r);
    `CHK(opMode, MODE_STBY_HIGH)
    `CHK({powerDownFlag, wdtTimeoutFlag}, 2'b10)
    wr(ADDR_CPUCTL, 8'h02, 4'hF, r);
    `CHK(opMode, MODE_SLOW)
    $display("test command halt done");
    wr(ADDR_CPUCTL, 8'h04, 4'hF, r);
    `CHK({powerDownFlag, wdtTimeoutFlag}, 2'b00)
    rd(ADDR_CPUCTL, d, r);
    `CHK(d, 8'h00)
    $display("test watchdog clear done");
    complete_run();
  end
endmodule // testbench
